/* File: design/bdmd_pkg.sv */
// Package for the branch and data-move execution block.
// Assumes a 16-bit instruction word plus one extension word for direct access.
package bdmd_pkg;

  // Instruction classes in bits [15:12]
  localparam logic [3:0] OP_BRANCH = 4'h1;
  localparam logic [3:0] OP_COPY   = 4'h2;
  localparam logic [3:0] OP_IMM    = 4'h3;
  localparam logic [3:0] OP_PIN    = 4'h4;
  localparam logic [3:0] OP_POUT   = 4'h5;
  localparam logic [3:0] OP_PRD    = 4'h6;
  localparam logic [3:0] OP_PWR    = 4'h7;
  localparam logic [3:0] OP_DRD    = 4'h8;
  localparam logic [3:0] OP_DWR    = 4'h9;
  localparam logic [3:0] OP_ARD    = 4'hA;
  localparam logic [3:0] OP_AWR    = 4'hB;
  localparam logic [3:0] OP_PMRD   = 4'hC;

  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Pointer select and address modes
  localparam logic [1:0] PTR_X      = 2'h0;
  localparam logic [1:0] PTR_Y      = 2'h1;
  localparam logic [1:0] PTR_Z      = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST  = 2'h1;
  localparam logic [1:0] MODE_PRE   = 2'h2;

  // Register indices
  localparam logic [4:0] IDX_R0   = 5'h00;
  localparam logic [4:0] IDX_IMM  = 5'h10;
  localparam logic [4:0] IDX_X_LO = 5'h1A;
  localparam logic [4:0] IDX_Y_LO = 5'h1C;
  localparam logic [4:0] IDX_Z_LO = 5'h1E;

  // Software-visible map
  localparam logic [5:0] ADR_STATUS = 6'h20;
  localparam logic [5:0] ADR_PC_LO  = 6'h21;
  localparam logic [5:0] ADR_PC_HI  = 6'h22;

  localparam logic [7:0]  GPR_RESET = 8'h00;
  localparam logic [15:0] PC_RESET  = 16'h0000;

  // Cycle counts
  localparam int CYC_BR_NOT = 1;
  localparam int CYC_BR_TAK = 2;
  localparam int CYC_DMEM   = 2;
  localparam int CYC_PMEM   = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BR, ST_LD, ST_ST, ST_PM1, ST_PM2
  } bdmd_state_e;

  function automatic logic [15:0] bdmd_sext_k(input logic [6:0] k);
    return {{9{k[6]}}, k};
  endfunction

endpackage

/* File: design/bdmd_rf_if.sv */
// Interface between the executor and the general register file.
// Assumes one clock; all reads are combinational.
`timescale 1ns/1ps
interface bdmd_rf_if;
  logic [4:0]  ra_idx;
  logic [7:0]  ra_data;
  logic [4:0]  rb_idx;
  logic [7:0]  rb_data;
  logic        we;
  logic [4:0]  w_idx;
  logic [7:0]  w_data;
  logic        pwe;
  logic [1:0]  p_sel;
  logic [15:0] p_wdata;
  logic [15:0] x;
  logic [15:0] y;
  logic [15:0] z;

  modport core (output ra_idx, rb_idx, we, w_idx, w_data, pwe, p_sel,
                p_wdata, input ra_data, rb_data, x, y, z);
  modport rf   (input ra_idx, rb_idx, we, w_idx, w_data, pwe, p_sel,
                p_wdata, output ra_data, rb_data, x, y, z);
endinterface

/* File: design/bdmd_regfile.sv */
// General register file, 32 by 8, with X, Y, Z pointer views.
// Assumes a single clock; pointer write overrides a byte write to its pair.
`timescale 1ns/1ps
module bdmd_regfile (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  bdmd_rf_if.rf     rf
);
  import bdmd_pkg::*;

  logic [7:0] gpr_q [32];
  logic [4:0] plo;

  assign rf.ra_data = gpr_q[rf.ra_idx];
  assign rf.rb_data = gpr_q[rf.rb_idx];
  assign rf.x       = {gpr_q[IDX_X_LO + 5'h01], gpr_q[IDX_X_LO]};
  assign rf.y       = {gpr_q[IDX_Y_LO + 5'h01], gpr_q[IDX_Y_LO]};
  assign rf.z       = {gpr_q[IDX_Z_LO + 5'h01], gpr_q[IDX_Z_LO]};
  assign plo = (rf.p_sel == PTR_X) ? IDX_X_LO :
               (rf.p_sel == PTR_Y) ? IDX_Y_LO : IDX_Z_LO;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 32; i++) gpr_q[i] <= GPR_RESET;
    end else begin
      if (rf.we) gpr_q[rf.w_idx] <= rf.w_data;
      if (rf.pwe) begin
        gpr_q[plo]          <= rf.p_wdata[7:0];
        gpr_q[plo + 5'h01]  <= rf.p_wdata[15:8];
      end
    end
  end
endmodule // bdmd_regfile

/* File: design/bdmd_branch.sv */
// Relative branch condition and target evaluation.
// Assumes status flags arrive from the shared status register, same clock.
`timescale 1ns/1ps
module bdmd_branch #(
  parameter int PC_W = 16
) (
  input  wire logic [7:0]      sreg_i,
  input  wire logic [2:0]      sel_i,
  input  wire logic            pol_i,
  input  wire logic [6:0]      k_i,
  input  wire logic [PC_W-1:0] pc_i,
  output logic                 take_o,
  output logic [PC_W-1:0]      target_o
);
  import bdmd_pkg::*;

  logic flag;

  // Signed tests use N xor V directly
  assign flag = (sel_i == FLAG_S) ? (sreg_i[FLAG_N] ^ sreg_i[FLAG_V])
                                  : sreg_i[sel_i];
  // Polarity 1 branches on a set flag, 0 on a clear flag
  assign take_o = (flag == pol_i);
  // Same test serves the remaining flags
  assign target_o = pc_i + PC_W'(bdmd_sext_k(k_i)) + PC_W'(1);
endmodule // bdmd_branch

/* File: design/bdmd_core.sv */
// Executor for relative branches, register moves, data memory, program
// memory and port transfers. Assumes memories answer one cycle after a
// read strobe and ports answer in the same cycle; flags are owned outside.
//
// Functional notes
// - Carry-clear and same-or-higher branches jump only when C=0.
// - Signed greater-or-equal branch taken when N xor V is 0.
// - Signed less-than branch taken when N xor V is 1.
// - Half-carry-set branch jumps only when H=1; flags untouched.
// - Half-carry-clear branch jumps only when H=0; flags untouched.
// - T-set branch jumps only when T=1.
// - T-clear branch jumps only when T=0.
// - Overflow-set branch jumps only when V=1.
// - Overflow-clear branch jumps only when V=0.
// - Interrupt-enabled branch jumps only when I=1.
// - Interrupt-disabled branch jumps only when I=0.
// - Register copy moves source to destination in one cycle.
// - Post-increment load reads at pointer, then pointer+1; two cycles.
// - Pre-decrement load: pointer-1, then read new address; two cycles.
// - Displaced load reads pointer+q, pointer unchanged; two cycles.
// - Direct load reads absolute address from instruction; two cycles.
// - Post-increment store writes at pointer, then pointer+1; two cycles.
// - Pre-decrement store decrements pointer, writes there; two cycles.
// - Displaced store writes pointer+q, pointer unchanged; two cycles.
// - Direct store writes absolute address, two cycles, no flags.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module bdmd_core #(
  parameter int PC_W = 16
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  input  wire logic [15:0] INSTR_I,
  input  wire logic [15:0] INSTR_EXT_I,
  input  wire logic        INSTR_VALID_I,
  output logic             READY_O,
  output logic             RETIRE_O,
  output logic [15:0]      PC_O,
  input  wire logic [7:0]  SREG_I,
  output logic [15:0]      DM_ADDR_O,
  output logic [7:0]       DM_WDATA_O,
  output logic             DM_RE_O,
  output logic             DM_WE_O,
  input  wire logic [7:0]  DM_RDATA_I,
  output logic [15:0]      PM_ADDR_O,
  output logic             PM_RE_O,
  input  wire logic [15:0] PM_RDATA_I,
  output logic [5:0]       IO_ADDR_O,
  output logic [7:0]       IO_WDATA_O,
  output logic             IO_RE_O,
  output logic             IO_WE_O,
  input  wire logic [7:0]  IO_RDATA_I,
  input  wire logic [5:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [7:0]       REG_RDATA_O
);
  import bdmd_pkg::*;

  if (PC_W < 8 || PC_W > 16) begin : g_chk
    $error("PC_W must lie between 8 and 16");
  end

  bdmd_rf_if rf ();

  bdmd_state_e      state_q;
  bdmd_state_e      state_d;
  logic [PC_W-1:0]  pc_q;
  logic [PC_W-1:0]  br_tgt_q;
  logic [4:0]       dst_q;
  logic             pm_hi_q;
  logic [7:0]       pm_byte_q;
  logic [7:0]       reg_rdata_q;

  logic [3:0]       op;
  logic             acc;
  logic             is_br;
  logic             is_ld;
  logic             is_st;
  logic             is_pm;
  logic             br_take;
  logic [PC_W-1:0]  br_tgt;
  logic [1:0]       ptr_sel;
  logic [1:0]       mode;
  logic [15:0]      ptr;
  logic [15:0]      eaddr;
  logic             core_we;

  function automatic logic [15:0] ptr_of(input logic [1:0] sel,
                                         input logic [15:0] x,
                                         input logic [15:0] y,
                                         input logic [15:0] z);
    return (sel == PTR_X) ? x : (sel == PTR_Y) ? y : z;
  endfunction

  assign op      = INSTR_I[15:12];
  assign READY_O = (state_q == ST_IDLE);
  assign acc     = INSTR_VALID_I && READY_O;
  assign is_br   = (op == OP_BRANCH);
  assign is_ld   = (op == OP_PRD) || (op == OP_DRD) || (op == OP_ARD);
  assign is_st   = (op == OP_PWR) || (op == OP_DWR) || (op == OP_AWR);
  assign is_pm   = (op == OP_PMRD);
  assign mode    = INSTR_I[4:3];
  assign ptr_sel = (op == OP_PRD || op == OP_PWR) ? INSTR_I[6:5]
                 : (INSTR_I[6] ? PTR_Z : PTR_Y);
  assign ptr     = ptr_of(ptr_sel, rf.x, rf.y, rf.z);

  bdmd_branch #(.PC_W(PC_W)) u_branch (
    .sreg_i   (SREG_I),
    .sel_i    (INSTR_I[10:8]),
    .pol_i    (INSTR_I[11]),
    .k_i      (INSTR_I[6:0]),
    .pc_i     (pc_q),
    .take_o   (br_take),
    .target_o (br_tgt)
  );

  bdmd_regfile u_regfile (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .rf      (rf)
  );

  // Effective data address
  always_comb begin
    case (op)
      OP_PRD, OP_PWR: eaddr = (mode == MODE_PRE) ? ptr - 16'h0001
                                                 : ptr;
      OP_DRD, OP_DWR: eaddr = ptr + {10'h000, INSTR_I[5:0]};
      OP_ARD, OP_AWR: eaddr = INSTR_EXT_I;
      default:        eaddr = 16'h0000;
    endcase
  end

  assign DM_ADDR_O  = eaddr;
  assign DM_RE_O    = acc && is_ld;
  assign DM_WE_O    = acc && is_st;
  assign DM_WDATA_O = rf.ra_data;
  assign PM_ADDR_O  = {1'b0, rf.z[15:1]};
  assign PM_RE_O    = acc && is_pm;
  assign IO_ADDR_O  = INSTR_I[5:0];
  assign IO_WDATA_O = rf.ra_data;
  assign IO_RE_O    = acc && (op == OP_PIN);
  assign IO_WE_O    = acc && (op == OP_POUT);

  // Pointer update for post-increment and pre-decrement forms
  assign rf.p_sel   = ptr_sel;
  assign rf.pwe     = acc && (op == OP_PRD || op == OP_PWR) &&
                      (mode == MODE_POST || mode == MODE_PRE);
  assign rf.p_wdata = (mode == MODE_POST) ? ptr + 16'h0001
                                          : ptr - 16'h0001;

  // Source operand for copy and stores and port output
  always_comb begin
    case (op)
      OP_COPY: rf.ra_idx = INSTR_I[4:0];
      OP_POUT: rf.ra_idx = INSTR_I[10:6];
      default: rf.ra_idx = INSTR_I[11:7];
    endcase
  end
  assign rf.rb_idx = REG_ADDR_I[4:0];

  // Single register write port; core first, software when core is quiet
  always_comb begin
    core_we     = 1'b1;
    rf.w_idx    = dst_q;
    rf.w_data   = DM_RDATA_I;
    if (state_q == ST_LD) begin
      rf.w_data = DM_RDATA_I;
    end else if (state_q == ST_PM2) begin
      rf.w_data = pm_byte_q;
    end else if (acc && op == OP_COPY) begin
      rf.w_idx  = INSTR_I[9:5];
      rf.w_data = rf.ra_data;
    end else if (acc && op == OP_IMM) begin
      rf.w_idx  = IDX_IMM + {1'b0, INSTR_I[11:8]};
      rf.w_data = INSTR_I[7:0];
    end else if (acc && op == OP_PIN) begin
      rf.w_idx  = INSTR_I[10:6];
      rf.w_data = IO_RDATA_I;
    end else begin
      core_we   = 1'b0;
      rf.w_idx  = REG_ADDR_I[4:0];
      rf.w_data = REG_WDATA_I;
    end
  end
  assign rf.we = core_we || (REG_WR_I && !REG_ADDR_I[5]);

  // Sequencing of multi-cycle forms
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (acc) begin
          if (is_br && br_take) state_d = ST_BR;
          else if (is_ld)       state_d = ST_LD;
          else if (is_st)       state_d = ST_ST;
          else if (is_pm)       state_d = ST_PM1;
        end
      end
      ST_PM1:  state_d = ST_PM2;
      ST_BR, ST_LD, ST_ST, ST_PM2: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) state_q <= ST_IDLE;
    else           state_q <= state_d;
  end

  assign RETIRE_O = (acc && state_d == ST_IDLE) ||
                    (state_q != ST_IDLE && state_d == ST_IDLE);

  // Program counter
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pc_q     <= PC_W'(PC_RESET);
      br_tgt_q <= PC_W'(PC_RESET);
    end else if (state_q == ST_BR) begin
      pc_q     <= br_tgt_q;
    end else if (acc) begin
      br_tgt_q <= br_tgt;
      if (!(is_br && br_take)) begin
        pc_q <= pc_q + ((op == OP_ARD || op == OP_AWR) ? PC_W'(2)
                                                       : PC_W'(1));
      end
    end
  end
  assign PC_O = 16'(pc_q);

  // Destination and program memory byte capture
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dst_q     <= IDX_R0;
      pm_hi_q   <= 1'b0;
      pm_byte_q <= 8'h00;
    end else begin
      if (acc) begin
        dst_q   <= (is_pm && !INSTR_I[6]) ? IDX_R0 : INSTR_I[11:7];
        pm_hi_q <= rf.z[0];
      end
      if (state_q == ST_PM1) begin
        pm_byte_q <= pm_hi_q ? PM_RDATA_I[15:8] : PM_RDATA_I[7:0];
      end
    end
  end

  // Software read port, data one cycle after the strobe
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      reg_rdata_q <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADR_STATUS: reg_rdata_q <= {7'h00, !READY_O};
        ADR_PC_LO:  reg_rdata_q <= PC_O[7:0];
        ADR_PC_HI:  reg_rdata_q <= PC_O[15:8];
        default:    reg_rdata_q <= REG_ADDR_I[5] ? 8'h00 : rf.rb_data;
      endcase
    end
  end
  assign REG_RDATA_O = reg_rdata_q;

  // Checks
  logic [15:0] exp_tgt;
  logic        br_acc;
  assign exp_tgt = PC_O + bdmd_sext_k(INSTR_I[6:0]) + 16'h0001;
  assign br_acc  = acc && is_br;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);

  AST_BR_CS_TAKEN: assert property (
    br_acc && INSTR_I[11] && INSTR_I[10:8] == FLAG_C && SREG_I[0]
    |=> !READY_O ##1 (READY_O && PC_O == $past(exp_tgt, 2)))
    else $error("carry-set branch not taken in two cycles");
  AST_BR_CC_FALL: assert property (
    br_acc && !INSTR_I[11] && INSTR_I[10:8] == FLAG_C && SREG_I[0]
    |=> READY_O && PC_O == $past(PC_O) + 16'h0001)
    else $error("carry-clear branch did not fall through");
  AST_BR_GE: assert property (
    br_acc && !INSTR_I[11] && INSTR_I[10:8] == FLAG_S &&
    !(SREG_I[2] ^ SREG_I[3]) |-> ##2 PC_O == $past(exp_tgt, 2))
    else $error("signed ge branch target wrong");
  AST_BR_LT: assert property (
    br_acc && INSTR_I[11] && INSTR_I[10:8] == FLAG_S &&
    !(SREG_I[2] ^ SREG_I[3]) |=> READY_O)
    else $error("signed lt branch taken without N xor V");
  AST_BR_HS_FALL: assert property (
    br_acc && INSTR_I[11] && INSTR_I[10:8] == FLAG_H && !SREG_I[5]
    |=> PC_O == $past(PC_O) + 16'h0001)
    else $error("half-carry-set branch taken with H clear");
  AST_COPY: assert property (
    acc && op == OP_COPY |-> rf.we && rf.w_idx == INSTR_I[9:5] ##1 READY_O)
    else $error("register copy not one cycle");
  AST_LD_POST: assert property (
    acc && op == OP_PRD && mode == MODE_POST && INSTR_I[6:5] == PTR_X
    |-> DM_RE_O && DM_ADDR_O == rf.x
    ##1 !READY_O && rf.x == $past(rf.x) + 16'h0001 ##1 READY_O)
    else $error("post-increment load wrong");
  AST_LD_PRE: assert property (
    acc && op == OP_PRD && mode == MODE_PRE && INSTR_I[6:5] == PTR_Z
    |=> rf.z == $past(DM_ADDR_O) && rf.z == $past(rf.z) - 16'h0001)
    else $error("pre-decrement load address wrong");
  AST_ST_PRE: assert property (
    acc && op == OP_PWR && mode == MODE_PRE && INSTR_I[6:5] == PTR_X
    |-> DM_WE_O && DM_ADDR_O == rf.x - 16'h0001
    ##1 !READY_O ##1 READY_O)
    else $error("pre-decrement store wrong");
  AST_DIRECT_ST: assert property (
    acc && op == OP_AWR |-> DM_WE_O && DM_ADDR_O == INSTR_EXT_I
    ##1 !READY_O ##1 (READY_O && PC_O == $past(PC_O, 2) + 16'h0002))
    else $error("direct store wrong");
  AST_PMEM_3CYC: assert property (
    acc && is_pm |=> !READY_O [*2] ##1 READY_O)
    else $error("program memory read not three cycles");
  AST_ONE_CYCLE: assert property (
    acc && (op == OP_IMM || op == OP_PIN || op == OP_POUT) |-> RETIRE_O)
    else $error("port or immediate transfer not one cycle");
  AST_BR_HC_TAKEN: assert property (
    br_acc && !INSTR_I[11] && INSTR_I[10:8] == FLAG_H && !SREG_I[5]
    |=> !READY_O ##1 (READY_O && PC_O == $past(exp_tgt, 2)))
    else $error("half-carry-clear branch not taken in two cycles");
  AST_DISP_LD: assert property (
    acc && op == OP_DRD && !INSTR_I[6]
    |-> DM_RE_O && DM_ADDR_O == rf.y + {10'h000, INSTR_I[5:0]}
    ##1 !READY_O && rf.y == $past(rf.y) ##1 READY_O)
    else $error("displaced load wrong");
  AST_DIRECT_LD: assert property (
    acc && op == OP_ARD |-> DM_RE_O && DM_ADDR_O == INSTR_EXT_I
    ##1 (RETIRE_O && rf.we) ##1 READY_O)
    else $error("direct load wrong");
  AST_ST_POST: assert property (
    acc && op == OP_PWR && mode == MODE_POST && INSTR_I[6:5] == PTR_Y
    |-> DM_WE_O && DM_ADDR_O == rf.y
    ##1 !READY_O && rf.y == $past(rf.y) + 16'h0001)
    else $error("post-increment store wrong");
  AST_DISP_ST: assert property (
    acc && op == OP_DWR && INSTR_I[6]
    |-> DM_WE_O && DM_ADDR_O == rf.z + {10'h000, INSTR_I[5:0]}
    ##1 !READY_O && rf.z == $past(rf.z))
    else $error("displaced store wrong");

  COV_BR_TAKEN: cover property (br_acc && br_take);
  COV_BR_BACK:  cover property (br_acc && br_take && INSTR_I[6]);
  COV_LOAD:     cover property (acc && is_ld ##2 READY_O);
  COV_PMEM:     cover property (state_q == ST_PM2);
  COV_SW_READ:  cover property (REG_RD_I && REG_ADDR_I == ADR_STATUS);

endmodule // bdmd_core

/* File: dv/bdmd_mem_model.sv */
// Behavioural data memory, program memory and port space for the executor.
// Assumes one clock; memories answer one cycle after a strobe, ports at once.
`timescale 1ns/1ps
module bdmd_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i,
  input  wire logic        dm_re_i,
  input  wire logic        dm_we_i,
  output logic [7:0]       dm_rdata_o,
  input  wire logic [15:0] pm_addr_i,
  input  wire logic        pm_re_i,
  output logic [15:0]      pm_rdata_o,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_re_i,
  input  wire logic        io_we_i,
  output logic [7:0]       io_rdata_o,
  output logic [23:0]      wr_last_o,
  output logic [13:0]      io_last_o
);
  logic [7:0]  mem [256];
  logic [7:0]  dm_q;
  logic [15:0] pm_q;
  logic        dm_v_q = 1'h0;
  logic        pm_v_q = 1'h0;
  logic [7:0]  junk_q = 8'h96;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  always @(posedge clk_i) begin
    junk_q <= junk_q + 8'h3B;
    dm_v_q <= dm_re_i;
    pm_v_q <= pm_re_i;
    dm_q   <= mem[dm_addr_i[7:0]];
    pm_q   <= {~pm_addr_i[7:0], pm_addr_i[7:0]};
    if (dm_we_i) begin
      mem[dm_addr_i[7:0]] <= dm_wdata_i;
      wr_last_o           <= {dm_addr_i, dm_wdata_i};
    end
    if (io_we_i) begin
      io_last_o <= {io_addr_i, io_wdata_i};
    end
  end

  // Outside a read answer the lines show a pattern that moves every cycle
  assign dm_rdata_o = dm_v_q ? dm_q : junk_q;
  assign pm_rdata_o = pm_v_q ? pm_q : {junk_q, ~junk_q};
  assign io_rdata_o = io_re_i ? (8'hC0 | {2'h0, io_addr_i}) : junk_q;
endmodule // bdmd_mem_model

/* File: dv/test_branch_and_data_move_decode.sv */
// Self-checking bench for the branch and data-move executor.
// Assumes the memory model in this folder and the software register port.
`timescale 1ns/1ps
module test_branch_and_data_move_decode;
  import bdmd_pkg::*;
  logic        MCLK_I, RESETN_I, INSTR_VALID_I, READY_O, RETIRE_O;
  logic        DM_RE_O, DM_WE_O, PM_RE_O, IO_RE_O, IO_WE_O;
  logic        REG_WR_I, REG_RD_I;
  logic [15:0] INSTR_I, INSTR_EXT_I, PC_O, DM_ADDR_O, PM_ADDR_O, PM_RDATA_I;
  logic [7:0]  SREG_I, DM_WDATA_O, DM_RDATA_I, IO_WDATA_O, IO_RDATA_I;
  logic [7:0]  REG_WDATA_I, REG_RDATA_O;
  logic [5:0]  IO_ADDR_O, REG_ADDR_I;
  logic [23:0] wr_last;
  logic [13:0] io_last;
  logic [15:0] pc_x;
  logic [15:0] ins;
  int          bad_count = 0;
  int          tests_run = 0;

  // Rows: taken, status flags, instruction
  localparam logic [24:0] BR_ROWS [24] = '{
    {1'h1, 8'h01, 16'h1805},
    {1'h0, 8'h00, 16'h183F},
    {1'h0, 8'h01, 16'h1005},
    {1'h1, 8'h00, 16'h107F},
    {1'h0, 8'h04, 16'h1405},
    {1'h1, 8'h1C, 16'h1440},
    {1'h1, 8'h04, 16'h1C05},
    {1'h0, 8'h00, 16'h1C05},
    {1'h1, 8'h20, 16'h1D05},
    {1'h0, 8'h00, 16'h1D05},
    {1'h0, 8'h20, 16'h1505},
    {1'h1, 8'h00, 16'h1503},
    {1'h1, 8'h40, 16'h1E05},
    {1'h0, 8'h00, 16'h1E05},
    {1'h1, 8'h00, 16'h1605},
    {1'h0, 8'h40, 16'h1605},
    {1'h1, 8'h08, 16'h1B05},
    {1'h0, 8'h00, 16'h1B05},
    {1'h0, 8'h08, 16'h1305},
    {1'h1, 8'h00, 16'h1305},
    {1'h0, 8'h00, 16'h1F05},
    {1'h1, 8'h80, 16'h1F05},
    {1'h1, 8'h00, 16'h1705},
    {1'h0, 8'h80, 16'h1705}
  };

  bdmd_core #(.PC_W(16)) dut (
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .INSTR_I(INSTR_I),
    .INSTR_EXT_I(INSTR_EXT_I), .INSTR_VALID_I(INSTR_VALID_I),
    .READY_O(READY_O), .RETIRE_O(RETIRE_O), .PC_O(PC_O), .SREG_I(SREG_I),
    .DM_ADDR_O(DM_ADDR_O), .DM_WDATA_O(DM_WDATA_O), .DM_RE_O(DM_RE_O),
    .DM_WE_O(DM_WE_O), .DM_RDATA_I(DM_RDATA_I), .PM_ADDR_O(PM_ADDR_O),
    .PM_RE_O(PM_RE_O), .PM_RDATA_I(PM_RDATA_I), .IO_ADDR_O(IO_ADDR_O),
    .IO_WDATA_O(IO_WDATA_O), .IO_RE_O(IO_RE_O), .IO_WE_O(IO_WE_O),
    .IO_RDATA_I(IO_RDATA_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O));

  bdmd_mem_model mdl (
    .clk_i(MCLK_I), .dm_addr_i(DM_ADDR_O), .dm_wdata_i(DM_WDATA_O),
    .dm_re_i(DM_RE_O), .dm_we_i(DM_WE_O), .dm_rdata_o(DM_RDATA_I),
    .pm_addr_i(PM_ADDR_O), .pm_re_i(PM_RE_O), .pm_rdata_o(PM_RDATA_I),
    .io_addr_i(IO_ADDR_O), .io_wdata_i(IO_WDATA_O), .io_re_i(IO_RE_O),
    .io_we_i(IO_WE_O), .io_rdata_o(IO_RDATA_I), .wr_last_o(wr_last),
    .io_last_o(io_last));

  always #50 MCLK_I = ~MCLK_I;

  task automatic tally_and_finish();
    $display("%0d comparisons, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge MCLK_I);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    REG_WR_I    <= 1'h1;
    @(posedge MCLK_I);
    REG_WR_I    <= 1'h0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    @(posedge MCLK_I);
    REG_ADDR_I <= a;
    REG_RD_I   <= 1'h1;
    @(posedge MCLK_I);
    REG_RD_I   <= 1'h0;
    @(negedge MCLK_I);
    check({16'h0000, REG_RDATA_O}, {16'h0000, e});
  endtask

  task automatic set_ptr(input logic [4:0] lo, input logic [15:0] v);
    reg_wr({1'h0, lo}, v[7:0]);
    reg_wr({1'h0, lo + 5'h01}, v[15:8]);
  endtask

  // Issues one instruction and counts cycles up to its retire pulse
  task automatic run(input logic [15:0] i, input logic [15:0] ext,
                     input logic [23:0] ecyc);
    logic [23:0] cyc;
    logic        done;
    cyc  = 24'h000000;
    done = 1'h0;
    @(posedge MCLK_I);
    INSTR_I       <= i;
    INSTR_EXT_I   <= ext;
    INSTR_VALID_I <= 1'h1;
    repeat (6) begin
      if (!done) begin
        @(negedge MCLK_I);
        cyc  = cyc + 24'h000001;
        done = (RETIRE_O === 1'h1);
        @(posedge MCLK_I);
        INSTR_VALID_I <= 1'h0;
      end
    end
    if (!done) begin
      bad_count++;
      tally_and_finish();
    end else begin
      check(cyc, ecyc);
    end
  endtask

  initial begin
    MCLK_I = 1'h0;
    RESETN_I = 1'h0;
    INSTR_I = 16'h0000;
    INSTR_EXT_I = 16'h0000;
    INSTR_VALID_I = 1'h0;
    SREG_I = 8'h00;
    REG_ADDR_I = 6'h00;
    REG_WDATA_I = 8'h00;
    REG_WR_I = 1'h0;
    REG_RD_I = 1'h0;
    repeat (16) @(posedge MCLK_I);
    RESETN_I <= 1'h1;
    @(negedge MCLK_I);
    check({8'h00, PC_O}, 24'h000000);
    check({23'h000000, READY_O}, 24'h000001);
    $display("reset test done");

    pc_x = 16'h0000;
    for (int r = 0; r < 24; r++) begin
      @(posedge MCLK_I);
      SREG_I <= BR_ROWS[r][23:16];
      ins = BR_ROWS[r][15:0];
      run(ins, 16'h0000,
          BR_ROWS[r][24] ? 24'(CYC_BR_TAK) : 24'(CYC_BR_NOT));
      pc_x = pc_x + (BR_ROWS[r][24] ?
             {{9{ins[6]}}, ins[6:0]} + 16'h0001 : 16'h0001);
      @(negedge MCLK_I);
      check({8'h00, PC_O}, {8'h00, pc_x});
    end
    rchk(ADR_PC_LO, pc_x[7:0]);
    rchk(ADR_PC_HI, pc_x[15:8]);
    reg_wr(ADR_STATUS, 8'hFF);
    rchk(ADR_STATUS, 8'h00);
    rchk(6'h3F, 8'h00);
    $display("branch table test done");

    reg_wr(6'h01, 8'hA5);
    run(16'h2041, 16'h0000, 24'h000001);
    rchk(6'h02, 8'hA5);
    run(16'h335A, 16'h0000, 24'h000001);
    rchk(6'h13, 8'h5A);
    run(16'h54CA, 16'h0000, 24'h000001);
    @(negedge MCLK_I);
    check({10'h000, io_last}, 24'h000A5A);
    run(16'h4515, 16'h0000, 24'h000001);
    rchk(6'h14, 8'hD5);
    $display("one-cycle transfer test done");

    set_ptr(IDX_X_LO, 16'h0010);
    run(16'h6188, 16'h0000, 24'h000002);
    rchk(6'h03, 8'h4A);
    rchk(IDX_X_LO, 8'h11);
    set_ptr(IDX_Z_LO, 16'h0100);
    run(16'h6250, 16'h0000, 24'h000002);
    rchk(6'h04, 8'hA5);
    rchk(6'h1F, 8'h00);
    set_ptr(IDX_Y_LO, 16'h0020);
    run(16'h82BF, 16'h0000, 24'h000002);
    rchk(6'h05, 8'h05);
    rchk(IDX_Y_LO, 8'h20);
    run(16'hA300, 16'h0077, 24'h000002);
    rchk(6'h06, 8'h2D);
    $display("load test done");

    run(16'h70A8, 16'h0000, 24'h000002);
    check(wr_last, 24'h0020A5);
    rchk(IDX_Y_LO, 8'h21);
    run(16'h7090, 16'h0000, 24'h000002);
    check(wr_last, 24'h0010A5);
    rchk(IDX_X_LO, 8'h10);
    run(16'h90C1, 16'h0000, 24'h000002);
    check(wr_last, 24'h0100A5);
    rchk(IDX_Z_LO, 8'hFF);
    run(16'hB080, 16'h1234, 24'h000002);
    check(wr_last, 24'h1234A5);
    $display("store test done");

    set_ptr(IDX_Z_LO, 16'h0101);
    run(16'hC3C0, 16'h0000, 24'(CYC_PMEM));
    rchk(6'h07, 8'h7F);
    reg_wr(IDX_Z_LO, 8'h00);
    run(16'hC000, 16'h0000, 24'(CYC_PMEM));
    rchk(IDX_R0, 8'h80);
    $display("program read test done");

    // Reset lands while a program read is in its second cycle
    @(posedge MCLK_I);
    INSTR_I       <= 16'hC3C0;
    INSTR_VALID_I <= 1'h1;
    @(posedge MCLK_I);
    INSTR_VALID_I <= 1'h0;
    RESETN_I      <= 1'h0;
    @(negedge MCLK_I);
    check({23'h000000, READY_O}, 24'h000001);
    check({8'h00, PC_O}, 24'h000000);
    check({16'h0000, REG_RDATA_O}, 24'h000000);
    repeat (2) @(posedge MCLK_I);
    RESETN_I <= 1'h1;
    rchk(6'h07, 8'h00);
    rchk(IDX_R0, 8'h00);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // test_branch_and_data_move_decode
